// ---- hw/bus_release_pkg.sv ----
// Constants, states and timing figures of the bus-release handshake.
// Behaviour
// - Float the whole memory bus at least two interface clocks after the request falls.
// - Drive the grant low zero to two interface clocks after the bus floats.
// - Re-drive the bus two to seven interface clocks after the request rises.
// - Return the grant high zero to two interface clocks after re-driving the bus.
// - Selected output clocks float and return with the same delays as the bus; the code floats and re-drives them one block clock after the bus.
// - Per-clock select: zero keeps the clock toggling, one floats it while released.
// - Finish pending memory transfers before granting; an idle bus gets the minimum delay.
// - While the block bit is one, never grant the bus; the code checks it only while draining.
// - Floated set covers enables, data, address, strobes, clock enable, third enable, transfer strobe.
// - All delays count periods of the selected interface input clock.
// - Update the bus-request status only on a rising memory output clock edge.
package bus_release_pkg;

	// Period of the interface clock and of the block clock, both in ns.
	localparam int IFC_PERIOD_NS = 8;
	localparam int CLK_PERIOD_NS = 8;

	// Delay figures in interface clock periods, as printed.
	localparam int FLOAT_MIN_E = 2;
	localparam int GRANT_MAX_E = 2;
	localparam int RESUME_MIN_E = 2;
	localparam int RESUME_MAX_E = 7;
	localparam int UNGRANT_MAX_E = 2;

	// Cycle counts: least times round up, longest times round down.
	localparam int FLOAT_MIN_CYC = (FLOAT_MIN_E * IFC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRANT_MAX_CYC = (GRANT_MAX_E * IFC_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int RESUME_MIN_CYC = (RESUME_MIN_E * IFC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESUME_MAX_CYC = (RESUME_MAX_E * IFC_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int UNGRANT_MAX_CYC = (UNGRANT_MAX_E * IFC_PERIOD_NS) / CLK_PERIOD_NS;

	// Counter width for the release delays.
	localparam int DLY_W = 4;

	// Reset values of the pin-side controls.
	localparam logic GRANT_N_RST = 1'b1;
	localparam logic BUS_DRIVE_RST = 1'b1;
	localparam logic STATUS_RST = 1'b0;

	// Handshake states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DRAIN,
		ST_FLOATED,
		ST_GRANTED,
		ST_RESUME,
		ST_REDRIVEN
	} release_state_e;

endpackage : bus_release_pkg

// ---- hw/release_delay_counter.sv ----
// Saturating up-counter that times the release delays.
module release_delay_counter #(
	parameter int WIDTH = 4
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Control.
	input wire logic clear_i,
	// Count value.
	output logic [WIDTH-1:0] count_o
);

	logic [WIDTH-1:0] count_ff;

	// Restart on clear, otherwise count up and hold at the top.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || clear_i) begin
			count_ff <= '0;
		end else if (count_ff != {WIDTH{1'b1}}) begin
			count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign count_o = count_ff;

endmodule : release_delay_counter

// ---- hw/memory_clock_gen.sv ----
// Memory output clocks divided from the block clock, each with its own float control.
module memory_clock_gen #(
	parameter int NUM_CLKS = 2
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Float control.
	input wire logic float_active_i,
	input wire logic [NUM_CLKS-1:0] clock_out_float_sel_i,
	// Output clocks.
	output logic [NUM_CLKS-1:0] memory_out_clk_o,
	output logic [NUM_CLKS-1:0] memory_out_clk_oe_o,
	output logic rise_pulse_o
);

	logic phase_ff;
	logic [NUM_CLKS-1:0] oe_ff;

	// The output clock runs at half the block clock rate.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			phase_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
		end
	end

	// Each clock floats only when its select bit is set during a release.
	genvar i;
	generate
		for (i = 0; i < NUM_CLKS; i++) begin : g_clk
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					oe_ff[i] <= 1'b1;
				end else begin
					oe_ff[i] <= ~(float_active_i & clock_out_float_sel_i[i]);
				end
			end
			assign memory_out_clk_o[i] = phase_ff;
		end
	endgenerate

	assign memory_out_clk_oe_o = oe_ff;
	// Marks the block cycle whose closing edge is a rising edge of the output clock.
	assign rise_pulse_o = ~phase_ff;

endmodule : memory_clock_gen

// ---- hw/ext_bus_release_arbiter.sv ----
// Bus-release handshake: hands the external memory bus to an outside master and takes it back.
module ext_bus_release_arbiter #(
	parameter int NUM_CLKS = 2
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Release handshake with the outside master.
	input wire logic bus_release_req_n_i,
	output logic bus_release_grant_n_o,
	output logic bus_request_status_o,
	// Configuration.
	input wire logic release_block_bit_i,
	input wire logic [NUM_CLKS-1:0] clock_out_float_sel_i,
	// Memory controller side.
	input wire logic xfer_pending_i,
	input wire logic xfer_wanted_i,
	output logic cycle_start_inhibit_o,
	input wire logic [3:0] ctl_chip_enable_n_i,
	input wire logic [7:0] ctl_byte_enable_n_i,
	input wire logic [63:0] ctl_memory_data_i,
	input wire logic [22:3] ctl_memory_address_i,
	input wire logic [2:0] ctl_strobe_n_i,
	input wire logic ctl_memory_clock_enable_i,
	input wire logic ctl_output_enable_three_n_i,
	input wire logic ctl_peripheral_transfer_strobe_n_i,
	output logic [63:0] ctl_read_data_o,
	// Memory bus pins.
	output logic [3:0] chip_enable_n_o,
	output logic chip_enable_n_oe_o,
	output logic [7:0] byte_enable_n_o,
	output logic byte_enable_n_oe_o,
	input wire logic [63:0] memory_data_i,
	output logic [63:0] memory_data_o,
	output logic memory_data_oe_o,
	output logic [22:3] memory_address_o,
	output logic memory_address_oe_o,
	output logic [2:0] strobe_n_o,
	output logic strobe_n_oe_o,
	output logic memory_clock_enable_o,
	output logic memory_clock_enable_oe_o,
	output logic output_enable_three_n_o,
	output logic output_enable_three_n_oe_o,
	output logic peripheral_transfer_strobe_n_o,
	output logic peripheral_transfer_strobe_n_oe_o,
	// Memory output clocks.
	output logic [NUM_CLKS-1:0] memory_out_clk_o,
	output logic [NUM_CLKS-1:0] memory_out_clk_oe_o
);
	import bus_release_pkg::*;

	// Handshake state and release timing.
	release_state_e state_ff;
	release_state_e nxt_state;
	logic grant_n_ff;
	logic bus_drive_ff;
	logic clk_float_ff;
	logic status_ff;
	logic dly_clear;
	logic clk_rise;
	logic [DLY_W-1:0] dly_count;

	// Registered pin values and the read-back path.
	logic [3:0] chip_enable_n_ff;
	logic [7:0] byte_enable_n_ff;
	logic [63:0] memory_data_ff;
	logic [22:3] memory_address_ff;
	logic [2:0] strobe_n_ff;
	logic memory_clock_enable_ff;
	logic output_enable_three_n_ff;
	logic peripheral_transfer_strobe_n_ff;
	logic [63:0] read_data_ff;

	// True once the delay counter has reached the given number of cycles.
	function automatic logic reached(input logic [DLY_W-1:0] count, input int limit);
		reached = (count >= limit[DLY_W-1:0]);
	endfunction : reached

	// True on the step from draining into the floated state.
	// Bus drive and clock float both key on it, so they can never disagree about the edge.
	function automatic logic float_step(input release_state_e cur, input release_state_e nxt);
		float_step = (cur == ST_DRAIN) && (nxt == ST_FLOATED);
	endfunction : float_step

	// True on the step from the resume wait into the re-driven state.
	function automatic logic redrive_step(input release_state_e cur, input release_state_e nxt);
		redrive_step = (cur == ST_RESUME) && (nxt == ST_REDRIVEN);
	endfunction : redrive_step

	// Times the float and re-drive delays in cycles of the interface clock, which is the block clock.
	release_delay_counter #(
		.WIDTH(DLY_W)
	) u_delay (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.clear_i(dly_clear),
		.count_o(dly_count)
	);

	// Generates the memory output clocks and floats the selected ones during a release.
	memory_clock_gen #(
		.NUM_CLKS(NUM_CLKS)
	) u_clk (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.float_active_i(clk_float_ff),
		.clock_out_float_sel_i(clock_out_float_sel_i),
		.memory_out_clk_o(memory_out_clk_o),
		.memory_out_clk_oe_o(memory_out_clk_oe_o),
		.rise_pulse_o(clk_rise)
	);

	// The counter restarts whenever the handshake changes state.
	assign dly_clear = (nxt_state != state_ff);

	// Next-state logic of the release handshake.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				// Wait for the outside master to ask for the bus.
				if (!bus_release_req_n_i) begin
					nxt_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// A request withdrawn before the bus floats simply ends the release.
				if (bus_release_req_n_i) begin
					nxt_state = ST_IDLE;
				end else if (release_block_bit_i) begin
					nxt_state = ST_DRAIN;
				end else if (!xfer_pending_i && reached(dly_count, FLOAT_MIN_CYC - 1)) begin
					nxt_state = ST_FLOATED;
				end
			end
			ST_FLOATED: begin
				// The pins are off; the grant follows on the next edge.
				nxt_state = ST_GRANTED;
			end
			ST_GRANTED: begin
				// The master keeps its request low at least one cycle past the grant.
				if (bus_release_req_n_i) begin
					nxt_state = ST_RESUME;
				end
			end
			ST_RESUME: begin
				// Keep the pins off for the least resume delay.
				if (reached(dly_count, RESUME_MIN_CYC - 1)) begin
					nxt_state = ST_REDRIVEN;
				end
			end
			ST_REDRIVEN: begin
				// The pins are back; withdraw the grant.
				nxt_state = ST_IDLE;
			end
			default: begin
				// An unused encoding falls back to idle.
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Bus drive: floats on entry to the floated state and returns on entry to the re-driven state.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			bus_drive_ff <= BUS_DRIVE_RST;
		end else if (float_step(state_ff, nxt_state)) begin
			bus_drive_ff <= 1'b0;
		end else if (redrive_step(state_ff, nxt_state)) begin
			bus_drive_ff <= 1'b1;
		end
	end

	// Output clock float follows the bus float on the same edges.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			clk_float_ff <= 1'b0;
		end else if (float_step(state_ff, nxt_state)) begin
			clk_float_ff <= 1'b1;
		end else if (redrive_step(state_ff, nxt_state)) begin
			clk_float_ff <= 1'b0;
		end
	end

	// Grant falls one cycle after the float and rises one cycle after the re-drive.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			grant_n_ff <= GRANT_N_RST;
		end else if (state_ff == ST_FLOATED) begin
			grant_n_ff <= 1'b0;
		end else if (state_ff == ST_REDRIVEN) begin
			grant_n_ff <= 1'b1;
		end
	end

	// Status shows that the controller wants the bus back; it moves only on output clock rises.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			status_ff <= STATUS_RST;
		end else if (clk_rise) begin
			status_ff <= xfer_wanted_i && (state_ff != ST_IDLE);
		end
	end

	// Strobes and enables reset to their inactive levels, except the clock enable, which resets high; the memories see no cycle.
	// These are registered copies: each pin lags the controller by one edge.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			chip_enable_n_ff <= 4'h f;
			byte_enable_n_ff <= 8'h ff;
			strobe_n_ff <= 3'h 7;
			memory_clock_enable_ff <= 1'b1;
			output_enable_three_n_ff <= 1'b1;
			peripheral_transfer_strobe_n_ff <= 1'b1;
		end else begin
			chip_enable_n_ff <= ctl_chip_enable_n_i;
			byte_enable_n_ff <= ctl_byte_enable_n_i;
			strobe_n_ff <= ctl_strobe_n_i;
			memory_clock_enable_ff <= ctl_memory_clock_enable_i;
			output_enable_three_n_ff <= ctl_output_enable_three_n_i;
			peripheral_transfer_strobe_n_ff <= ctl_peripheral_transfer_strobe_n_i;
		end
	end

	// Address copy; it reaches the pins only while the device owns the bus.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			memory_address_ff <= '0;
		end else begin
			memory_address_ff <= ctl_memory_address_i;
		end
	end

	// Write data copy; it reaches the pins only while the data drive is on.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			memory_data_ff <= '0;
		end else begin
			memory_data_ff <= ctl_memory_data_i;
		end
	end

	// Read data captured from the data pins.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			read_data_ff <= '0;
		end else begin
			read_data_ff <= memory_data_i;
		end
	end

	// The controller may start no new cycle from the request until the grant is withdrawn.
	assign cycle_start_inhibit_o = (state_ff != ST_IDLE) || !bus_release_req_n_i;

	// Control and address pin values.
	assign chip_enable_n_o = chip_enable_n_ff;
	assign byte_enable_n_o = byte_enable_n_ff;
	assign memory_data_o = memory_data_ff;
	assign memory_address_o = memory_address_ff;
	assign strobe_n_o = strobe_n_ff;
	assign memory_clock_enable_o = memory_clock_enable_ff;
	assign output_enable_three_n_o = output_enable_three_n_ff;
	assign peripheral_transfer_strobe_n_o = peripheral_transfer_strobe_n_ff;

	// Data pins and the read-back path.
	assign ctl_read_data_o = read_data_ff;

	// The whole floated set shares one drive flop.
	assign chip_enable_n_oe_o = bus_drive_ff;
	assign byte_enable_n_oe_o = bus_drive_ff;
	// Data lines also stay off while the controller wants the bus back.
	assign memory_data_oe_o = bus_drive_ff && !xfer_wanted_i;
	assign memory_address_oe_o = bus_drive_ff;
	assign strobe_n_oe_o = bus_drive_ff;
	assign memory_clock_enable_oe_o = bus_drive_ff;
	assign output_enable_three_n_oe_o = bus_drive_ff;
	assign peripheral_transfer_strobe_n_oe_o = bus_drive_ff;

	// Handshake outputs.
	assign bus_release_grant_n_o = grant_n_ff;
	assign bus_request_status_o = status_ff;

endmodule : ext_bus_release_arbiter

// ---- testbench/bus_release_asserts.sv ----
// Port checker for the bus-release handshake.
module bus_release_asserts #(
	parameter int NUM_CLKS = 2
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Handshake and configuration.
	input wire logic bus_release_req_n_i,
	input wire logic bus_release_grant_n_o,
	input wire logic bus_request_status_o,
	input wire logic release_block_bit_i,
	input wire logic xfer_pending_i,
	input wire logic [NUM_CLKS-1:0] clock_out_float_sel_i,
	input wire logic cycle_start_inhibit_o,
	// Drive enables and output clocks.
	input wire logic chip_enable_n_oe_o,
	input wire logic byte_enable_n_oe_o,
	input wire logic memory_address_oe_o,
	input wire logic strobe_n_oe_o,
	input wire logic memory_clock_enable_oe_o,
	input wire logic output_enable_three_n_oe_o,
	input wire logic peripheral_transfer_strobe_n_oe_o,
	input wire logic [NUM_CLKS-1:0] memory_out_clk_o,
	input wire logic [NUM_CLKS-1:0] memory_out_clk_oe_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	// The bus stays floated for two edges after the request lifts, then returns.
	sequence s_resume;
		!memory_address_oe_o [*2] ##[1:6] memory_address_oe_o;
	endsequence
	// Selected clocks stay floated for two edges, then every clock is driven again.
	sequence s_clk_resume;
		(memory_out_clk_oe_o == ~clock_out_float_sel_i) [*2] ##[1:6] (&memory_out_clk_oe_o);
	endsequence
	AST_FLOAT_MIN: assert property ($fell(bus_release_req_n_i) |-> memory_address_oe_o [*2])
		else $error("bus floated early");
	AST_CLK_FLOAT_MIN: assert property ($fell(bus_release_req_n_i) |-> (&memory_out_clk_oe_o) [*2])
		else $error("clock floated early");
	AST_GRANT: assert property ($fell(memory_address_oe_o) |-> ##[0:2] !bus_release_grant_n_o)
		else $error("grant late");
	AST_RESUME: assert property ($rose(bus_release_req_n_i) && !bus_release_grant_n_o |-> s_resume)
		else $error("re-drive out of window");
	AST_CLK_RESUME: assert property ($rose(bus_release_req_n_i) && !bus_release_grant_n_o |-> s_clk_resume)
		else $error("clock re-drive out of window");
	AST_UNGRANT: assert property ($rose(memory_address_oe_o) |-> ##[0:2] bus_release_grant_n_o)
		else $error("grant not returned");
	AST_PENDING: assert property (xfer_pending_i && bus_release_grant_n_o && memory_address_oe_o |=> memory_address_oe_o)
		else $error("floated with transfer pending");
	AST_BLOCK: assert property (release_block_bit_i && bus_release_grant_n_o && memory_address_oe_o |=> memory_address_oe_o)
		else $error("floated while blocked");
	AST_BUS_SET: assert property ({chip_enable_n_oe_o, byte_enable_n_oe_o, strobe_n_oe_o, memory_clock_enable_oe_o,
		output_enable_three_n_oe_o, peripheral_transfer_strobe_n_oe_o} == {6{memory_address_oe_o}})
		else $error("bus enables differ");
	AST_INHIBIT: assert property (!bus_release_grant_n_o |-> cycle_start_inhibit_o)
		else $error("cycle allowed while granted");
	AST_STATUS: assert property ($changed(bus_request_status_o) |-> $rose(memory_out_clk_o[0]))
		else $error("status off clock rise");
endmodule : bus_release_asserts

bind ext_bus_release_arbiter bus_release_asserts #(.NUM_CLKS(NUM_CLKS)) u_asserts (.clock_i, .rst_n_i,
	.bus_release_req_n_i, .bus_release_grant_n_o, .bus_request_status_o, .release_block_bit_i, .xfer_pending_i,
	.clock_out_float_sel_i, .cycle_start_inhibit_o, .chip_enable_n_oe_o, .byte_enable_n_oe_o, .memory_address_oe_o,
	.strobe_n_oe_o, .memory_clock_enable_oe_o, .output_enable_three_n_oe_o, .peripheral_transfer_strobe_n_oe_o,
	.memory_out_clk_o, .memory_out_clk_oe_o);

// ---- testbench/bus_master_model.sv ----
// Outside master that borrows the memory bus through the release handshake.
module bus_master_model (
	// Clock.
	input wire logic clock_i,
	// Bench control.
	input wire logic go_i,
	input wire logic [3:0] hold_i,
	// Handshake and bus.
	input wire logic grant_n_i,
	input wire logic bus_oe_i,
	output logic req_n_o,
	output logic [63:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial req_n_o = 1'h1;
	initial data_o = 64'h0;
	// Asks while told to, keeps asking hold_i edges past the grant, then lets go.
	always @(posedge clock_i) begin
		if (!go_i) begin
			req_n_o <= 1'h1;
			cnt <= 0;
		end else if (!grant_n_i && cnt < hold_i) begin
			cnt <= cnt + 1;
		end else begin
			req_n_o <= (cnt != 0);
		end
	end
	// Drives data only while granted and floated; otherwise a changing pattern.
	always @(posedge clock_i) begin
		data_o <= (!grant_n_i && !bus_oe_i) ? {16{hold_i}} : ~data_o;
	end
endmodule : bus_master_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the bus-release handshake.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bus_release_pkg::*;
	logic clock_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic release_block_bit_i = 1'h0;
	logic xfer_pending_i = 1'h0;
	logic xfer_wanted_i = 1'h0;
	logic go = 1'h0;
	logic [1:0] clock_out_float_sel_i = 2'h0;
	logic [3:0] hold = 4'h1;
	logic [3:0] ctl_chip_enable_n_i = 4'hf;
	logic [7:0] ctl_byte_enable_n_i = 8'hff;
	logic [63:0] ctl_memory_data_i = 64'h0;
	logic [22:3] ctl_memory_address_i = 20'h0;
	logic [2:0] ctl_strobe_n_i = 3'h7;
	logic ctl_memory_clock_enable_i = 1'h1;
	logic ctl_output_enable_three_n_i = 1'h1;
	logic ctl_peripheral_transfer_strobe_n_i = 1'h1;
	logic bus_release_req_n_i;
	logic bus_release_grant_n_o;
	logic bus_request_status_o;
	logic cycle_start_inhibit_o;
	logic memory_address_oe_o;
	logic [3:0] chip_enable_n_o;
	logic [7:0] byte_enable_n_o;
	logic [2:0] strobe_n_o;
	logic [22:3] memory_address_o;
	logic [63:0] memory_data_o;
	logic memory_data_oe_o;
	logic memory_clock_enable_o;
	logic output_enable_three_n_o;
	logic peripheral_transfer_strobe_n_o;
	logic [63:0] memory_data_i;
	logic [63:0] ctl_read_data_o;
	logic [1:0] memory_out_clk_oe_o;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int t0 = 0;
	int lo[$];
	int hi[$];

	always #4 clock_i = ~clock_i;

	ext_bus_release_arbiter #(.NUM_CLKS(2)) uut (.clock_i, .rst_n_i, .bus_release_req_n_i, .bus_release_grant_n_o,
		.bus_request_status_o, .release_block_bit_i, .clock_out_float_sel_i, .xfer_pending_i, .xfer_wanted_i,
		.cycle_start_inhibit_o, .ctl_chip_enable_n_i, .ctl_byte_enable_n_i, .ctl_memory_data_i, .ctl_memory_address_i,
		.ctl_strobe_n_i, .ctl_memory_clock_enable_i, .ctl_output_enable_three_n_i, .ctl_peripheral_transfer_strobe_n_i,
		.ctl_read_data_o, .chip_enable_n_o, .chip_enable_n_oe_o(), .byte_enable_n_o, .byte_enable_n_oe_o(),
		.memory_data_i, .memory_data_o, .memory_data_oe_o, .memory_address_o, .memory_address_oe_o,
		.strobe_n_o, .strobe_n_oe_o(), .memory_clock_enable_o, .memory_clock_enable_oe_o(),
		.output_enable_three_n_o, .output_enable_three_n_oe_o(), .peripheral_transfer_strobe_n_o,
		.peripheral_transfer_strobe_n_oe_o(), .memory_out_clk_o(), .memory_out_clk_oe_o);

	bus_master_model master (.clock_i, .go_i(go), .hold_i(hold), .grant_n_i(bus_release_grant_n_o),
		.bus_oe_i(memory_address_oe_o), .req_n_o(bus_release_req_n_i), .data_o(memory_data_i));

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic wait_gnt(input logic v);
		int i;
		for (i = 0; i < 100 && bus_release_grant_n_o !== v; i++) @(negedge clock_i);
		chk("grant level", v, bus_release_grant_n_o);
	endtask : wait_gnt

	// One release; n edges of pending transfer or block delay the grant.
	task automatic xfer(input int n, input logic blk, input logic [1:0] s);
		int m;
		m = n > FLOAT_MIN_CYC ? n : FLOAT_MIN_CYC;
		hold = 4'($urandom_range(4, 1));
		clock_out_float_sel_i = s;
		xfer_wanted_i = 1'($urandom);
		{ctl_chip_enable_n_i, ctl_byte_enable_n_i, ctl_strobe_n_i, ctl_memory_clock_enable_i,
			ctl_output_enable_three_n_i, ctl_peripheral_transfer_strobe_n_i} = 18'($urandom);
		ctl_memory_data_i = {$urandom, $urandom};
		ctl_memory_address_i = 20'($urandom);
		xfer_pending_i = n > 0 && !blk;
		release_block_bit_i = n > 0 && blk;
		// Latencies are seen one edge late by the monitor's sampling.
		lo.push_back(m + 1);
		hi.push_back(m + GRANT_MAX_CYC + 3);
		lo.push_back(RESUME_MIN_CYC + 1);
		hi.push_back(RESUME_MAX_CYC + UNGRANT_MAX_CYC + 1);
		go = 1'h1;
		repeat (n) @(negedge clock_i);
		xfer_pending_i = 1'h0;
		release_block_bit_i = 1'h0;
		wait_gnt(1'h0);
		repeat (2) @(negedge clock_i);
		chk("clock enables", 2'(~s), memory_out_clk_oe_o);
		chk("data drive", 1'h0, memory_data_oe_o);
		chk("status", xfer_wanted_i, bus_request_status_o);
		chk("inhibit", 1'h1, cycle_start_inhibit_o);
		chk("read data", {16{hold}}, ctl_read_data_o);
		wait_gnt(1'h1);
		go = 1'h0;
		@(negedge clock_i);
		chk("chip enables", ctl_chip_enable_n_i, chip_enable_n_o);
		chk("bus drive", 1'h1, memory_address_oe_o);
		chk("data drive", !xfer_wanted_i, memory_data_oe_o);
		chk("control pins", {ctl_byte_enable_n_i, ctl_strobe_n_i, ctl_memory_clock_enable_i,
			ctl_output_enable_three_n_i, ctl_peripheral_transfer_strobe_n_i, ctl_memory_address_i},
			{byte_enable_n_o, strobe_n_o, memory_clock_enable_o, output_enable_three_n_o,
			peripheral_transfer_strobe_n_o, memory_address_o});
		chk("data pins", ctl_memory_data_i, memory_data_o);
		$display("test release n=%0d sel=%0d done", n, s);
	endtask : xfer

	// Times each grant edge from its request edge and compares with the oldest note.
	always @(posedge clock_i) begin
		cyc++;
		if ($fell(bus_release_req_n_i) || $rose(bus_release_req_n_i)) t0 = cyc;
		if (rst_n_i && $changed(bus_release_grant_n_o)) begin
			if (lo.size() == 0) lo.push_back(-1);
			if (hi.size() == 0) hi.push_back(-1);
			checks++;
			if (cyc - t0 < lo[0] || cyc - t0 > hi[0]) begin
				fails++;
				$display("ERROR grant latency expected %0d..%0d seen %0d", lo[0], hi[0], cyc - t0);
			end
			void'(lo.pop_front());
			void'(hi.pop_front());
		end
	end

	initial begin
		void'($urandom(32'h748f_b589));
		repeat (16) @(negedge clock_i);
		rst_n_i = 1'h1;
		for (int s = 0; s < 4; s++) xfer(0, 1'h0, 2'(s));
		xfer(6, 1'h0, 2'h3);
		xfer(20, 1'h1, 2'h1);
		go = 1'h1;
		@(negedge clock_i);
		go = 1'h0;
		repeat (8) @(negedge clock_i);
		chk("abort grant", 1'h1, bus_release_grant_n_o);
		chk("abort drive", 1'h1, memory_address_oe_o);
		$display("test abort done");
		results();
	end

	initial begin
		#200000;
		fails++;
		results();
	end
endmodule : tb_top
